// ### rtl/fccd_pkg.sv
// package: constants and types of the coprocessor command decoder
// Operation
// - opcodes 02..07 decode as sum, difference, quotient, residue, product and copy.
// - opcode 0E rounds the source to an integral value kept in float format.
// - opcode 0F converts float to integer, 10 converts integer to float.
// - opcode 11 converts decimal to float, 12 converts float to decimal.
// - compare opcodes 0A plain, 0B signalling, 1A swapped, 1B signalling and swapped.
// - opcode 14 extracts the internal data register after a fault.
// - broadcast word is latched into the command register only on identity match.
// - identity field is bits 24..31; only identity number zero is answered.
// - sources come from bits 7..9 and 4..6, destination from bits 0..3.
// - while quiescent no internal register is touched and nothing else happens.
// - order is command, operands, operation, then status read.
// - each exception sets its sticky bit, which then stays set.
// - a mask bit of one lets the exception be raised; zero blocks it.
// - inexact is flagged only when no other exception occurred.
// - overflow when rounded exponent too large, underflow when too small.
// - invalid when a result cannot be stored or operands are illegal.
// - trapping NaN operands cause a trap; non-trapping NaNs never do.
// - extended format with nonzero exponent and zero explicit bit is unnormalized.
// - single and double hidden bit is one unless exponent zero, then denormalized.
// - idle opcode ends any operation without changing internal registers.
package fccd_pkg;
  // command word layout
  localparam int CMD_W = 32;
  localparam int ID_LSB = 24;
  localparam int ID_W = 8;
  localparam logic [7:0] OWN_ID = 8'h00;
  localparam int OP_LSB = 10;
  localparam int OP_W = 5;
  localparam int SRC1_LSB = 7;
  localparam int SRC2_LSB = 4;
  localparam int DST_LSB = 0;
  localparam int SRC_W = 3;
  localparam int DST_W = 4;
  localparam logic [31:0] CMD_RST = 32'h0000_0000;
  // opcodes
  localparam logic [4:0] OPC_SUM = 5'h02;
  localparam logic [4:0] OPC_DIFF = 5'h03;
  localparam logic [4:0] OPC_QUOT = 5'h04;
  localparam logic [4:0] OPC_RESIDUE = 5'h05;
  localparam logic [4:0] OPC_PRODUCT = 5'h06;
  localparam logic [4:0] OPC_COPY = 5'h07;
  localparam logic [4:0] OPC_STAT_RD = 5'h08;
  localparam logic [4:0] OPC_STAT_WR = 5'h09;
  localparam logic [4:0] OPC_COMPARE = 5'h0A;
  localparam logic [4:0] OPC_COMPARE_SIG = 5'h0B;
  localparam logic [4:0] OPC_MAGNITUDE = 5'h0C;
  localparam logic [4:0] OPC_ROOT = 5'h0D;
  localparam logic [4:0] OPC_RND_INT = 5'h0E;
  localparam logic [4:0] OPC_F2I = 5'h0F;
  localparam logic [4:0] OPC_I2F = 5'h10;
  localparam logic [4:0] OPC_D2F = 5'h11;
  localparam logic [4:0] OPC_F2D = 5'h12;
  localparam logic [4:0] OPC_IDLE = 5'h13;
  localparam logic [4:0] OPC_FAULT = 5'h14;
  localparam logic [4:0] OPC_SIGN_FLIP = 5'h17;
  localparam logic [4:0] OPC_DLOAD = 5'h18;
  localparam logic [4:0] OPC_COMPARE_SWP = 5'h1A;
  localparam logic [4:0] OPC_COMPARE_SIG_SWP = 5'h1B;
  // exception vector positions
  localparam int EXC_N = 4;
  localparam int EXC_INVALID = 0;
  localparam int EXC_OVERFLOW = 1;
  localparam int EXC_UNDERFLOW = 2;
  localparam int EXC_INEXACT = 3;
  localparam logic [3:0] STICKY_RST = 4'h0;
  // operand formats and class vector positions
  localparam logic [1:0] FMT_SINGLE = 2'h0;
  localparam logic [1:0] FMT_DOUBLE = 2'h1;
  localparam logic [1:0] FMT_EXT = 2'h2;
  localparam int CLS_N = 7;
  localparam int CLS_ZERO = 0;
  localparam int CLS_DENORM = 1;
  localparam int CLS_UNNORM = 2;
  localparam int CLS_UNNORM_ZERO = 3;
  localparam int CLS_INF = 4;
  localparam int CLS_NAN = 5;
  localparam int CLS_TNAN = 6;
  // transaction states, one-hot
  typedef enum logic [3:0] {
    ST_QUIET = 4'h1,
    ST_OPND = 4'h2,
    ST_EXEC = 4'h4,
    ST_STAT = 4'h8
  } fccd_state_t;
  // operation classes
  typedef enum logic [3:0] {
    OPK_NONE = 4'h0,
    OPK_ARITH = 4'h1,
    OPK_COPY = 4'h2,
    OPK_STATUS = 4'h3,
    OPK_COMPARE = 4'h4,
    OPK_UNARY = 4'h5,
    OPK_CONVERT = 4'h6,
    OPK_IDLE = 4'h7,
    OPK_FAULT = 4'h8,
    OPK_LOAD = 4'h9
  } fccd_opk_t;
endpackage

// ### rtl/fccd_opnd_class.sv
// operand classifier: zero, denormal, unnormal, infinity and NaN kinds
`timescale 1ns/1ps
module fccd_opnd_class
  import fccd_pkg::*;
(
  // operand
  input wire logic [1:0] i_fmt,
  input wire logic [79:0] i_word,
  // class flags
  output logic [CLS_N-1:0] o_cls
);
  logic [14:0] exp_f;
  logic [14:0] exp_max;
  logic [62:0] frac;
  logic frac_msb;
  logic lead;
  logic is_ext;

  // field extraction per format; missing upper exponent bits are zero
  always_comb begin
    is_ext = (i_fmt == FMT_EXT);
    exp_f = '0;
    exp_max = '0;
    frac = '0;
    frac_msb = 1'b0;
    lead = 1'b0;
    o_cls = '0;
    if (i_fmt == FMT_SINGLE) begin
      exp_f[7:0] = i_word[30:23];
      exp_max[7:0] = '1;
      frac[22:0] = i_word[22:0];
      frac_msb = i_word[22];
      lead = (exp_f != '0);
    end else if (i_fmt == FMT_DOUBLE) begin
      exp_f[10:0] = i_word[62:52];
      exp_max[10:0] = '1;
      frac[51:0] = i_word[51:0];
      frac_msb = i_word[51];
      lead = (exp_f != '0);
    end else begin
      exp_f = i_word[78:64];
      exp_max = '1;
      frac = i_word[62:0];
      frac_msb = i_word[62];
      lead = i_word[63];
    end
    // a NaN with its top fraction bit clear is the trapping kind
    if (exp_f == exp_max) begin
      o_cls[CLS_INF] = (frac == '0);
      o_cls[CLS_NAN] = (frac != '0);
      o_cls[CLS_TNAN] = (frac != '0) && !frac_msb;
    end else if (exp_f == '0) begin
      o_cls[CLS_ZERO] = (frac == '0) && !lead;
      o_cls[CLS_DENORM] = (frac != '0) && !lead;
    end else if (is_ext && !lead) begin
      o_cls[CLS_UNNORM] = 1'b1;
      o_cls[CLS_UNNORM_ZERO] = (frac == '0);
    end
  end
endmodule

// ### rtl/fccd_top.sv
// command decoder and transaction sequencer of the floating-point coprocessor
`timescale 1ns/1ps
module fccd_top
  import fccd_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // host bus pins, asynchronous to the clock
  input wire logic i_bcast,
  input wire logic i_cs_wr,
  input wire logic i_cs_rd,
  input wire logic [CMD_W-1:0] i_data,
  // datapath side, same clock
  input wire logic i_cls_valid,
  input wire logic [1:0] i_cls_fmt,
  input wire logic [79:0] i_cls_word,
  input wire logic i_exec_done,
  input wire logic i_res_invalid,
  input wire logic i_res_ovf,
  input wire logic i_res_unf,
  input wire logic i_res_inexact,
  input wire logic [EXC_N-1:0] i_exc_mask,
  // decoded command
  output logic [OP_W-1:0] o_opcode,
  output fccd_opk_t o_op_kind,
  output logic [SRC_W-1:0] o_src1_sel,
  output logic [SRC_W-1:0] o_src2_sel,
  output logic [DST_W-1:0] o_dst_sel,
  output logic o_cmp_signal,
  output logic o_cmp_swap,
  // sequencing
  output logic o_busy,
  output logic o_exec_start,
  output logic o_fault_xtr,
  output logic o_abort,
  output logic o_stat_ack,
  // exceptions and classes
  output logic [EXC_N-1:0] o_exc_sticky,
  output logic [EXC_N-1:0] o_exc_raise,
  output logic o_trap,
  output logic [CLS_N-1:0] o_cls
);

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    fccd_state_t st;
    logic bc_s1;
    logic bc_s2;
    logic bc_d;
    logic wr_s1;
    logic wr_s2;
    logic wr_d;
    logic rd_s1;
    logic rd_s2;
    logic rd_d;
    logic [CMD_W-1:0] dat_s1;
    logic [CMD_W-1:0] dat_s2;
    logic [CMD_W-1:0] cmd;
    fccd_opk_t kind;
    logic cmp_swap;
    logic [1:0] need;
    logic nan_seen;
    logic tnan_seen;
    logic [EXC_N-1:0] cond;
    logic [EXC_N-1:0] sticky;
    logic [EXC_N-1:0] raise;
    logic trap;
    logic [CLS_N-1:0] cls;
    logic exec_start;
    logic fault_xtr;
    logic abort;
    logic stat_ack;
    logic busy;
  } fccd_q_t;

  fccd_q_t q_r;
  fccd_q_t q_nxt;

  ////////////////////////////////////////////////////////////////////////
  // decoding functions

  // operation class of an opcode
  function automatic fccd_opk_t op_kind(input logic [OP_W-1:0] op);
    fccd_opk_t k;
    k = OPK_NONE;
    unique case (op)
      OPC_SUM, OPC_DIFF, OPC_QUOT, OPC_RESIDUE, OPC_PRODUCT: k = OPK_ARITH;
      OPC_COPY: k = OPK_COPY;
      OPC_STAT_RD, OPC_STAT_WR: k = OPK_STATUS;
      OPC_COMPARE, OPC_COMPARE_SIG, OPC_COMPARE_SWP, OPC_COMPARE_SIG_SWP: k = OPK_COMPARE;
      OPC_MAGNITUDE, OPC_ROOT, OPC_SIGN_FLIP, OPC_RND_INT: k = OPK_UNARY;
      OPC_F2I, OPC_I2F, OPC_D2F, OPC_F2D: k = OPK_CONVERT;
      OPC_IDLE: k = OPK_IDLE;
      OPC_FAULT: k = OPK_FAULT;
      OPC_DLOAD: k = OPK_LOAD;
      default: k = OPK_NONE;
    endcase
    return k;
  endfunction

  // number of operand transfers that precede the operation
  function automatic logic [1:0] opnd_need(input logic [OP_W-1:0] op);
    logic [1:0] n;
    unique case (op_kind(op))
      OPK_ARITH, OPK_COMPARE: n = 2'h2;
      OPK_FAULT: n = 2'h0;
      OPK_STATUS: n = (op == OPC_STAT_RD) ? 2'h0 : 2'h1;
      default: n = 2'h1;
    endcase
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // combinational helpers

  logic bc_edge;
  logic wr_edge;
  logic rd_edge;
  logic id_hit;
  logic take;
  logic stop_op;
  logic [OP_W-1:0] new_op;
  logic [CLS_N-1:0] cls_c;
  logic cmp_sig;
  logic [EXC_N-1:0] cond_c;

  // edges are taken from the second synchroniser stage only
  assign bc_edge = q_r.bc_s2 & ~q_r.bc_d;
  assign wr_edge = q_r.wr_s2 & ~q_r.wr_d;
  assign rd_edge = q_r.rd_s2 & ~q_r.rd_d;
  assign id_hit = (q_r.dat_s2[ID_LSB +: ID_W] == OWN_ID);
  assign take = bc_edge & id_hit;
  assign new_op = q_r.dat_s2[OP_LSB +: OP_W];
  // idle and reserved words end things without touching any register
  assign stop_op = (op_kind(new_op) == OPK_IDLE) || (op_kind(new_op) == OPK_NONE);
  assign cmp_sig = (o_opcode == OPC_COMPARE_SIG) || (o_opcode == OPC_COMPARE_SIG_SWP);

  // operand classifier
  fccd_opnd_class u_class (
    .i_fmt (i_cls_fmt),
    .i_word (i_cls_word),
    .o_cls (cls_c)
  );

  // exception conditions at the end of an operation
  always_comb begin
    cond_c = '0;
    cond_c[EXC_INVALID] = i_res_invalid | q_r.tnan_seen | (cmp_sig & q_r.nan_seen);
    cond_c[EXC_OVERFLOW] = i_res_ovf;
    cond_c[EXC_UNDERFLOW] = i_res_unf;
    cond_c[EXC_INEXACT] = i_res_inexact & ~(cond_c[EXC_INVALID] | i_res_ovf | i_res_unf);
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    q_nxt = q_r;
    // two-stage synchronisers for the bus pins
    q_nxt.bc_s1 = i_bcast;
    q_nxt.bc_s2 = q_r.bc_s1;
    q_nxt.bc_d = q_r.bc_s2;
    q_nxt.wr_s1 = i_cs_wr;
    q_nxt.wr_s2 = q_r.wr_s1;
    q_nxt.wr_d = q_r.wr_s2;
    q_nxt.rd_s1 = i_cs_rd;
    q_nxt.rd_s2 = q_r.rd_s1;
    q_nxt.rd_d = q_r.rd_s2;
    q_nxt.dat_s1 = i_data;
    q_nxt.dat_s2 = q_r.dat_s1;
    // one-cycle pulses default low
    q_nxt.exec_start = 1'b0;
    q_nxt.fault_xtr = 1'b0;
    q_nxt.abort = 1'b0;
    q_nxt.stat_ack = 1'b0;
    q_nxt.raise = '0;
    q_nxt.cond = '0;
    q_nxt.cls = cls_c;
    // quiescent: classification never traps or marks a NaN as seen
    q_nxt.trap = i_cls_valid & cls_c[CLS_TNAN] & (q_r.st != ST_QUIET);
    if (i_cls_valid && (q_r.st != ST_QUIET)) begin
      q_nxt.nan_seen = q_r.nan_seen | cls_c[CLS_NAN];
      q_nxt.tnan_seen = q_r.tnan_seen | cls_c[CLS_TNAN];
    end
    if (take && stop_op) begin
      // abort wins over anything else this cycle, registers untouched
      if (q_r.st != ST_QUIET) begin
        q_nxt.st = ST_QUIET;
        q_nxt.abort = 1'b1;
      end
    end else begin
      unique case (q_r.st)
        ST_QUIET: begin
          // only a matching broadcast leaves quiescence
          if (take) begin
            q_nxt.cmd = q_r.dat_s2;
            q_nxt.kind = op_kind(new_op);
            q_nxt.cmp_swap = new_op[OP_W-1] & (op_kind(new_op) == OPK_COMPARE);
            q_nxt.need = opnd_need(new_op);
            q_nxt.nan_seen = 1'b0;
            q_nxt.tnan_seen = 1'b0;
            if (opnd_need(new_op) == 2'h0) begin
              q_nxt.st = ST_EXEC;
              q_nxt.exec_start = 1'b1;
              q_nxt.fault_xtr = (op_kind(new_op) == OPK_FAULT);
            end else begin
              q_nxt.st = ST_OPND;
            end
          end
        end
        ST_OPND: begin
          // each chip-selected write carries one operand
          if (wr_edge) begin
            q_nxt.need = q_r.need - 2'h1;
            if (q_r.need == 2'h1) begin
              q_nxt.st = ST_EXEC;
              q_nxt.exec_start = 1'b1;
            end
          end
        end
        ST_EXEC: begin
          if (i_exec_done) begin
            q_nxt.cond = cond_c;
            q_nxt.sticky = q_r.sticky | cond_c;
            q_nxt.raise = cond_c & i_exc_mask;
            q_nxt.st = ST_STAT;
          end
        end
        ST_STAT: begin
          // the host's status read closes the transaction
          if (rd_edge) begin
            q_nxt.stat_ack = 1'b1;
            q_nxt.st = ST_QUIET;
          end
        end
      endcase
    end
    q_nxt.busy = (q_nxt.st != ST_QUIET);
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q_r <= '0;
      q_r.st <= ST_QUIET;
      q_r.cmd <= CMD_RST;
      q_r.sticky <= STICKY_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // outputs straight from the state flops
  assign o_opcode = q_r.cmd[OP_LSB +: OP_W];
  assign o_op_kind = q_r.kind;
  assign o_src1_sel = q_r.cmd[SRC1_LSB +: SRC_W];
  assign o_src2_sel = q_r.cmd[SRC2_LSB +: SRC_W];
  assign o_dst_sel = q_r.cmd[DST_LSB +: DST_W];
  assign o_cmp_signal = q_r.cmd[OP_LSB];
  assign o_cmp_swap = q_r.cmp_swap;
  assign o_busy = q_r.busy;
  assign o_exec_start = q_r.exec_start;
  assign o_fault_xtr = q_r.fault_xtr;
  assign o_abort = q_r.abort;
  assign o_stat_ack = q_r.stat_ack;
  assign o_exc_sticky = q_r.sticky;
  assign o_exc_raise = q_r.raise;
  assign o_trap = q_r.trap;
  assign o_cls = q_r.cls;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);

  property p_foreign_id;
    (bc_edge && !id_hit) |=> $stable(q_r.cmd);
  endproperty
  a_foreign_id: assert property (p_foreign_id)
    else $error("command latched for a foreign identity");

  property p_id_zero;
    $rose(o_busy) |-> $past(q_r.dat_s2[ID_LSB +: ID_W]) == OWN_ID;
  endproperty
  a_id_zero: assert property (p_id_zero)
    else $error("left quiescence without identity zero");

  property p_fields;
    $rose(o_busy) |-> (o_src1_sel == $past(q_r.dat_s2[9:7])) && (o_src2_sel == $past(q_r.dat_s2[6:4]))
      && (o_dst_sel == $past(q_r.dat_s2[3:0]));
  endproperty
  a_fields: assert property (p_fields)
    else $error("operand specifiers taken from wrong bits");

  property p_quiet;
    !o_busy |-> !o_exec_start && !o_trap && !o_fault_xtr;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("activity while quiescent");

  property p_order;
    o_stat_ack |-> $past(q_r.st) == ST_STAT && !o_busy;
  endproperty
  a_order: assert property (p_order)
    else $error("status read out of transaction order");

  property p_sticky;
    ##1 ((($past(o_exc_sticky) | q_r.cond) & ~o_exc_sticky) == '0);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("sticky bit lost or not set");

  property p_mask;
    ##1 ((o_exc_raise & ~$past(i_exc_mask)) == '0);
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked exception raised");

  property p_inexact;
    q_r.cond[EXC_INEXACT] |-> (q_r.cond[EXC_INEXACT-1:0] == '0);
  endproperty
  a_inexact: assert property (p_inexact)
    else $error("inexact beside another exception");

  property p_ovf;
    (q_r.st == ST_EXEC && i_exec_done && i_res_ovf && !(take && stop_op)) |=> q_r.cond[EXC_OVERFLOW] ##1 o_exc_sticky[EXC_OVERFLOW];
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow not flagged");

  property p_trap;
    (o_busy && i_cls_valid) |=> (o_trap == $past(cls_c[CLS_TNAN]));
  endproperty
  a_trap: assert property (p_trap)
    else $error("trap does not follow trapping NaN");

  property p_idle;
    (take && stop_op) |=> $stable(q_r.cmd) && $stable(o_exc_sticky) && !o_busy;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle or reserved command changed registers");

  c_full: cover property (o_exec_start ##[1:50] o_stat_ack);
  c_trap: cover property (o_trap);
  c_abort: cover property (o_abort);
  c_inexact: cover property (o_exc_sticky[EXC_INEXACT]);

endmodule

// ### testbench/fccd_host_model.sv
// host model: drives broadcast, operand write and status read strobes on the bus pins
`timescale 1ns/1ps
module fccd_host_model (
  // clock
  input wire logic i_ref_clk,
  // bus pins toward the coprocessor
  output logic o_bcast,
  output logic o_cs_wr,
  output logic o_cs_rd,
  output logic [31:0] o_data
);
  // strobes low and bus idle from time zero
  initial begin
    o_bcast = 1'b0;
    o_cs_wr = 1'b0;
    o_cs_rd = 1'b0;
    o_data = 32'h0000_0000;
  end

  //////////////////////////////////////////////////////////////////////////////
  // one access: kind 0 broadcast, 1 operand write, 2 status read
  // data settles 3 clocks before the strobe rises and holds 7 after it, since the pins are
  // double-flopped; afterwards the bus shows the inverse so a stale word never looks fresh
  task automatic access(input int unsigned kind, input logic [31:0] word, input int unsigned gap);
    repeat (gap + 1) @(posedge i_ref_clk);
    o_data <= word;
    repeat (3) @(posedge i_ref_clk);
    case (kind)
      0: o_bcast <= 1'b1;
      1: o_cs_wr <= 1'b1;
      default: o_cs_rd <= 1'b1;
    endcase
    repeat (4) @(posedge i_ref_clk);
    o_bcast <= 1'b0;
    o_cs_wr <= 1'b0;
    o_cs_rd <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    o_data <= ~word;
  endtask
endmodule

// ### testbench/testbench.sv
// self-checking bench of the command decoder: host model, expectation queue and monitor
`timescale 1ns/1ps
module testbench;
  import fccd_pkg::*;
  // event codes of the expectation queue
  localparam logic [3:0] E_CLS = 4'h1;
  localparam logic [3:0] E_TRAP = 4'h2;
  localparam logic [3:0] E_START = 4'h3;
  localparam logic [3:0] E_RAISE = 4'h4;
  localparam logic [3:0] E_ABORT = 4'h5;
  localparam logic [3:0] E_ACK = 4'h6;
  // opcode, operation class (f = class not checked) and operand count
  localparam logic [15:0] OP_TAB [22] = '{
    16'h0212, 16'h0312, 16'h0412, 16'h0512, 16'h0612, 16'h0721,
    16'h0830, 16'h0931, 16'h0a42, 16'h0b42, 16'h1a42, 16'h1b42,
    16'h0c51, 16'h0d51, 16'h0e51, 16'h0f61, 16'h1061, 16'h1161, 16'h1261,
    16'h1480, 16'h1751, 16'h1891
  };
  localparam logic [4:0] RSV [9] = '{5'h00, 5'h01, 5'h15, 5'h16, 5'h19, 5'h1c, 5'h1d, 5'h1e, 5'h1f};
  logic i_ref_clk, i_arst_n, i_bcast, i_cs_wr, i_cs_rd;
  logic [31:0] i_data;
  logic i_cls_valid, i_exec_done, i_res_invalid, i_res_ovf, i_res_unf, i_res_inexact, vld_d;
  logic [1:0] i_cls_fmt;
  logic [79:0] i_cls_word;
  logic [3:0] i_exc_mask, o_exc_sticky, o_exc_raise, sticky_exp, o_dst_sel;
  logic [4:0] o_opcode;
  fccd_opk_t o_op_kind;
  logic [2:0] o_src1_sel, o_src2_sel;
  logic o_cmp_signal, o_cmp_swap, o_busy, o_exec_start, o_fault_xtr, o_abort, o_stat_ack, o_trap;
  logic [6:0] o_cls;
  logic [67:0] notes_q [$];
  int miscompares, checked, seed;

  //////////////////////////////////////////////////////////////////////////////
  // design and host
  fccd_top dut_u (.i_ref_clk, .i_arst_n, .i_bcast, .i_cs_wr, .i_cs_rd, .i_data, .i_cls_valid, .i_cls_fmt,
    .i_cls_word, .i_exec_done, .i_res_invalid, .i_res_ovf, .i_res_unf, .i_res_inexact, .i_exc_mask,
    .o_opcode, .o_op_kind, .o_src1_sel, .o_src2_sel, .o_dst_sel, .o_cmp_signal, .o_cmp_swap, .o_busy,
    .o_exec_start, .o_fault_xtr, .o_abort, .o_stat_ack, .o_exc_sticky, .o_exc_raise, .o_trap, .o_cls);
  fccd_host_model host_u (.i_ref_clk, .o_bcast(i_bcast), .o_cs_wr(i_cs_wr), .o_cs_rd(i_cs_rd), .o_data(i_data));

  // 200 MHz clock
  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  // expectation queue and comparison
  task automatic note(input logic [3:0] code, input logic [31:0] care, input logic [31:0] val);
    notes_q.push_back({code, care, val & care});
  endtask
  task automatic cmp(input logic [35:0] obs, input logic [35:0] exp);
    checked++;
    if (obs !== exp) begin
      miscompares++;
      $display("FAIL at %0t: got %h expected %h", $time, obs, exp);
    end
  endtask
  // an event with nothing queued compares against code zero and so always fails
  task automatic take(input logic [3:0] code, input logic [31:0] obs);
    logic [67:0] n;
    n = '0;
    if (notes_q.size() != 0) n = notes_q.pop_front();
    cmp({code, obs & n[63:32]}, {n[67:64], n[31:0]});
  endtask

  // monitor samples mid-cycle, where the one-cycle pulses have settled
  always @(posedge i_ref_clk) vld_d <= i_cls_valid;
  always @(negedge i_ref_clk) begin
    if (i_arst_n === 1'b1) begin
      if (vld_d === 1'b1) take(E_CLS, 32'(o_cls));
      if (o_trap !== 1'b0) take(E_TRAP, 32'(o_trap));
      if (o_exec_start !== 1'b0) take(E_START, 32'({o_fault_xtr, o_cmp_swap, o_cmp_signal, o_opcode,
        o_op_kind, o_src1_sel, o_src2_sel, o_dst_sel}));
      if (o_exc_raise !== 4'h0) take(E_RAISE, 32'(o_exc_raise));
      if (o_abort !== 1'b0) take(E_ABORT, 32'({o_exc_sticky, o_busy, o_opcode}));
      if (o_stat_ack !== 1'b0) take(E_ACK, 32'({o_exc_sticky, o_busy}));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // stimulus tasks
  task automatic bcast(input logic [4:0] op);
    host_u.access(0, {OWN_ID, 9'h000, op, 10'h000}, 0);
  endtask
  // full transaction with random fields, random exception conditions and a random mask
  task automatic run_op(input logic [15:0] ent);
    logic [4:0] op;
    logic [3:0] kd, cond, msk, eff, d;
    logic [2:0] s1, s2;
    logic [31:0] care;
    int unsigned gap;
    op = ent[12:8];
    kd = ent[7:4];
    s1 = 3'($random(seed));
    s2 = 3'($random(seed));
    d = 4'($random(seed));
    cond = 4'($random(seed));
    msk = 4'($random(seed));
    gap = {$random(seed)} % 4;
    eff = {cond[3] & ~|cond[2:0], cond[2:0]};
    sticky_exp = sticky_exp | eff;
    care = (kd == 4'hf) ? 32'h003f_c3ff : 32'h003f_ffff;
    @(posedge i_ref_clk);
    i_exc_mask <= msk;
    note(E_START, care, {10'h000, op == OPC_FAULT, kd == 4'h4 && op[4], op[0], op, kd, s1, s2, d});
    host_u.access(0, {OWN_ID, 9'h000, op, s1, s2, d}, gap);
    repeat (ent[1:0]) host_u.access(1, $random(seed), gap);
    @(posedge i_ref_clk);
    {i_res_inexact, i_res_unf, i_res_ovf, i_res_invalid} <= cond;
    i_exec_done <= 1'b1;
    if ((eff & msk) != 4'h0) note(E_RAISE, 32'h0000_000f, 32'(eff & msk));
    @(posedge i_ref_clk);
    i_exec_done <= 1'b0;
    note(E_ACK, 32'h0000_001f, 32'({sticky_exp, 1'b0}));
    host_u.access(2, $random(seed), gap);
  endtask
  // one operand through the classifier, with an optional trap expected
  task automatic cls(input logic [1:0] fmt, input logic [79:0] w, input logic [6:0] val,
    input logic [6:0] care, input logic trap);
    @(posedge i_ref_clk);
    i_cls_fmt <= fmt;
    i_cls_word <= w;
    i_cls_valid <= 1'b1;
    note(E_CLS, 32'(care), 32'(val));
    if (trap) note(E_TRAP, 32'h0000_0001, 32'h0000_0001);
    @(posedge i_ref_clk);
    i_cls_valid <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
  endtask

  // leftover expectations count as misses
  task automatic tally_and_finish;
    if (notes_q.size() != 0) miscompares++;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // the run needs about 1300 cycles; the limit leaves ample room for slow host gaps
  initial begin
    #100_000;
    miscompares++;
    tally_and_finish;
  end

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 32'h8313_cd1e;
    miscompares = 0;
    checked = 0;
    sticky_exp = 4'h0;
    vld_d = 1'b0;
    i_arst_n = 1'b0;
    {i_cls_valid, i_exec_done, i_res_invalid, i_res_ovf, i_res_unf, i_res_inexact} = 6'h00;
    i_cls_fmt = 2'h0;
    i_cls_word = 80'h0000_0000_0000_0000_0000;
    i_exc_mask = 4'h0;
    repeat (5) @(posedge i_ref_clk);
    cmp(36'({o_busy, o_opcode, o_exc_sticky, o_op_kind}), 36'h0_0000_0000);
    i_arst_n <= 1'b1;
    // foreign identity, stray accesses and reserved opcodes in quiescent leave no trace
    host_u.access(0, {8'($random(seed)) | 8'h01, 9'h000, OPC_SUM, 10'h000}, 1);
    host_u.access(1, $random(seed), 0);
    host_u.access(2, $random(seed), 0);
    foreach (RSV[i]) bcast(RSV[i]);
    cmp(36'({o_busy, o_opcode, o_exc_sticky}), 36'h0_0000_0000);
    foreach (OP_TAB[i]) run_op(OP_TAB[i]);
    // second command while busy is ignored; idle aborts keeping command and sticky bits
    bcast(OPC_SUM);
    bcast(OPC_PRODUCT);
    host_u.access(1, $random(seed), 0);
    note(E_ABORT, 32'h0000_03ff, 32'({sticky_exp, 1'b0, OPC_SUM}));
    bcast(OPC_IDLE);
    // reserved broadcast during an operation aborts too
    note(E_START, 32'h003f_ffff, 32'({2'b00, OPC_DIFF[0], OPC_DIFF, 4'h1, 10'h000}));
    bcast(OPC_DIFF);
    repeat (2) host_u.access(1, $random(seed), 0);
    note(E_ABORT, 32'h0000_03ff, 32'({sticky_exp, 1'b0, OPC_DIFF}));
    bcast(5'h15);
    // operand classes in quiescent, no trap expected
    cls(FMT_SINGLE, 80'h0, 7'h01, 7'h7f, 1'b0);
    cls(FMT_SINGLE, 80'h0000_0001, 7'h02, 7'h7f, 1'b0);
    cls(FMT_SINGLE, 80'h3f80_0000, 7'h00, 7'h7f, 1'b0);
    cls(FMT_SINGLE, 80'h7f80_0000, 7'h10, 7'h7f, 1'b0);
    cls(FMT_SINGLE, 80'h7fc0_0000, 7'h20, 7'h7f, 1'b0);
    cls(FMT_DOUBLE, 80'h0000_0000_0000_0001, 7'h02, 7'h7f, 1'b0);
    cls(FMT_EXT, 80'h0001_4000_0000_0000_0000, 7'h04, 7'h7f, 1'b0);
    cls(FMT_EXT, 80'h0001_0000_0000_0000_0000, 7'h0c, 7'h7f, 1'b0);
    cls(FMT_EXT, 80'h0000_0000_0000_0000_0001, 7'h02, 7'h7f, 1'b0);
    // trapping and quiet NaN inside a transaction
    bcast(OPC_COPY);
    cls(FMT_SINGLE, 80'h7f80_0001, 7'h60, 7'h7f, 1'b1);
    cls(FMT_SINGLE, 80'h7fc0_0000, 7'h20, 7'h7f, 1'b0);
    note(E_ABORT, 32'h0000_03ff, 32'({sticky_exp, 1'b0, OPC_COPY}));
    bcast(OPC_IDLE);
    // any NaN met by a signalling compare makes the result invalid
    bcast(OPC_COMPARE_SIG);
    cls(FMT_SINGLE, 80'h7fc0_0000, 7'h20, 7'h7f, 1'b0);
    note(E_START, 32'h003f_ffff, 32'({3'b001, OPC_COMPARE_SIG, 4'h4, 10'h000}));
    repeat (2) host_u.access(1, $random(seed), 0);
    i_exc_mask <= 4'h1;
    {i_res_inexact, i_res_unf, i_res_ovf, i_res_invalid} <= 4'h0;
    i_exec_done <= 1'b1;
    note(E_RAISE, 32'h0000_000f, 32'h0000_0001);
    @(posedge i_ref_clk);
    i_exec_done <= 1'b0;
    sticky_exp = sticky_exp | 4'h1;
    note(E_ACK, 32'h0000_001f, 32'({sticky_exp, 1'b0}));
    host_u.access(2, $random(seed), 0);
    repeat (10) @(posedge i_ref_clk);
    tally_and_finish;
  end
endmodule
